// File: core/baro_ctrl_defs.vh
// Constants for the barometer control register bank.
// Assumes inclusion by bare name from the design files.
`ifndef BARO_CTRL_DEFS_VH
`define BARO_CTRL_DEFS_VH
// Register offsets (7-bit serial address)
`define ADDR_IDENTITY 7'h0f
`define ADDR_ACQ_CTRL 7'h10
`define ADDR_HK_CTRL 7'h11
`define ADDR_IRQ_CTRL 7'h12
`define ADDR_PRESS_HIGH 7'h2a
// Reset values
`define RST_ACQ_CTRL 8'h00
`define RST_HK_CTRL 8'h10
`define RST_IRQ_CTRL 8'h00
// Identity value, arbitrary
`define IDENTITY_VALUE 8'h5a
// Acquisition control fields
`define ACQ_RATE_HI 6
`define ACQ_RATE_LO 4
`define ACQ_FILT_EN 3
`define ACQ_FILT_CFG 2
`define ACQ_BDU 1
`define ACQ_WIRE 0
// Housekeeping fields
`define HK_RELOAD 7
`define HK_FIFO_EN 6
`define HK_HALT_WTM 5
`define HK_AUTO_INC 4
`define HK_I2C_OFF 3
`define HK_SOFT_RST 2
`define HK_ONE_SHOT 0
// Pin control fields
`define IRQ_POL 7
`define IRQ_OD 6
`define IRQ_FULL 5
`define IRQ_WTM 4
`define IRQ_OVR 3
`define IRQ_NEW_SAMPLE_TO_PIN 2
`define IRQ_SRC_HI 1
`define IRQ_SRC_LO 0
// Timing: core clock in Hz, conversion time of one sample in us
`define CORE_CLK_HZ 50000000
`define CONV_TIME_US 1000
`define CONV_CYCLES ((`CONV_TIME_US * (`CORE_CLK_HZ / 1000000)))
`define TRIM_CYCLES 16
`endif

// File: core/baro_rate_tick.v
// Conversion rate divider: one-cycle pulse at the selected rate.
// Assumes a 50 MHz single clock and a synchronous rate code.
`timescale 1ns/10ps
`default_nettype none
`include "baro_ctrl_defs.vh"
module baro_rate_tick #(
   parameter CLK_HZ = `CORE_CLK_HZ
) (
   input wire clk,
   input wire resetn,
   input wire [2:0] rate_select,
   output reg tick
);
   // Full-width periods less one, cut to the counter width where they are used
   localparam [31:0] LIM_1 = CLK_HZ / 1 - 1;
   localparam [31:0] LIM_10 = CLK_HZ / 10 - 1;
   localparam [31:0] LIM_25 = CLK_HZ / 25 - 1;
   localparam [31:0] LIM_50 = CLK_HZ / 50 - 1;
   localparam [31:0] LIM_75 = CLK_HZ / 75 - 1;

   reg [25:0] count_reg;
   reg [25:0] limit;

   // Period in cycles, less one, for rate codes 1 to 5; zero and codes 6 and 7 stop the divider
   always @* begin
      case (rate_select)
         3'h1: limit = LIM_1[25:0];
         3'h2: limit = LIM_10[25:0];
         3'h3: limit = LIM_25[25:0];
         3'h4: limit = LIM_50[25:0];
         3'h5: limit = LIM_75[25:0];
         default: limit = 26'h000_0000;
      endcase
   end

   // A count past a shorter new period wraps at once, so a rate change never stalls
   always @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         count_reg <= 26'h000_0000;
         tick <= 1'b0;
      end else if (limit == 26'h000_0000) begin
         count_reg <= 26'h000_0000;
         tick <= 1'b0;
      end else if (count_reg >= limit) begin
         count_reg <= 26'h000_0000;
         tick <= 1'b1;
      end else begin
         count_reg <= count_reg + 26'h000_0001;
         tick <= 1'b0;
      end
   end
endmodule // baro_rate_tick
`default_nettype wire

// File: core/baro_sensor_control_regs.v
// Control register bank of a barometric sensor: identity, acquisition,
// housekeeping and interrupt pin routing.
// Assumes a serial front end that hands over decoded byte accesses.
`timescale 1ns/10ps
`default_nettype none
`include "baro_ctrl_defs.vh"
module baro_sensor_control_regs #(
   parameter CONV_CYCLES = `CONV_CYCLES,
   parameter TRIM_CYCLES = `TRIM_CYCLES
) (
   input wire CORE_CLK,
   input wire RESETN,
   input wire [6:0] ACC_ADDR,
   input wire ACC_WR,
   input wire ACC_RD,
   input wire [7:0] ACC_WDATA,
   input wire ACC_FIRST,
   input wire [7:0] SAMPLE_IN,
   input wire FIFO_FULL,
   input wire FIFO_WTM,
   input wire FIFO_OVR,
   input wire PRESS_HIGH_EVT,
   input wire PRESS_LOW_EVT,
   output reg [7:0] ACC_RDATA,
   output reg [6:0] ACC_NEXT_ADDR,
   output reg [2:0] RATE_SELECT,
   output reg [1:0] BANDWIDTH_DIV,
   output reg POWERED_DOWN,
   output reg SPI_THREE_WIRE,
   output reg TWO_WIRE_BUS_OFF,
   output reg FIFO_ENABLE,
   output reg HALT_AT_WATERMARK,
   output reg TRIM_LOAD,
   output reg SAMPLE_STROBE,
   output reg [7:0] PRESSURE_HIGH_BYTE,
   output reg NEW_SAMPLE,
   output reg CFG_RESTORE,
   output reg IRQ_PIN_OUT,
   output reg IRQ_PIN_OE
);
   localparam ST_IDLE = 2'b00;
   localparam ST_CONV = 2'b01;
   localparam ST_DONE = 2'b10;

   reg [7:0] acq_reg;
   reg [7:0] hk_reg;
   reg [7:0] irq_reg;
   reg [1:0] state_reg;
   reg [31:0] conv_cnt_reg;
   reg [15:0] trim_cnt_reg;
   reg trim_busy_reg;
   reg trim_wait_reg;
   reg hold_reg;
   reg oneshot_run_reg;
   reg new_sample_to_pin_reg;
   reg [7:0] rd_mux;
   reg irq_level;
   wire rate_tick;
   wire [2:0] rate_now;
   wire acq_wr;
   wire hk_wr;
   wire irq_wr;
   wire conv_done;
   wire reload_clr;
   wire shot_clr;

   // Byte value with a single bit forced to a given level
   function [7:0] set_bit;
      input [7:0] v;
      input [2:0] pos;
      input b;
      begin
         set_bit = v;
         set_bit[pos] = b;
      end
   endfunction

   // Reload takes one rate period; in power-down there is no period to wait
   function rate_tick_or_idle;
      input t;
      input [2:0] r;
      begin
         rate_tick_or_idle = t | (r == 3'h0);
      end
   endfunction

   assign rate_now = acq_reg[`ACQ_RATE_HI:`ACQ_RATE_LO];
   assign acq_wr = ACC_WR && ACC_ADDR == `ADDR_ACQ_CTRL;
   assign hk_wr = ACC_WR && ACC_ADDR == `ADDR_HK_CTRL;
   assign irq_wr = ACC_WR && ACC_ADDR == `ADDR_IRQ_CTRL;
   assign conv_done = state_reg == ST_CONV && conv_cnt_reg == 32'h0000_0000;
   // Hardware clears of the command bits; reload_clr is used by the restore, write and idle branches below, shot_clr by the write and idle ones
   assign reload_clr = trim_wait_reg && rate_tick_or_idle(rate_tick, rate_now);
   assign shot_clr = state_reg == ST_DONE && oneshot_run_reg;

   baro_rate_tick u_rate (
      .clk(CORE_CLK),
      .resetn(RESETN),
      .rate_select(rate_now),
      .tick(rate_tick)
   );

   // Configuration registers; soft restore wins over an ordinary write
   always @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         acq_reg <= `RST_ACQ_CTRL;
         irq_reg <= `RST_IRQ_CTRL;
      end else if (hk_reg[`HK_SOFT_RST]) begin
         acq_reg <= `RST_ACQ_CTRL;
         irq_reg <= `RST_IRQ_CTRL;
      end else begin
         // Bit 7 is stored as zero whatever the host sends
         if (acq_wr) acq_reg <= {1'b0, ACC_WDATA[6:0]};
         if (irq_wr) irq_reg <= ACC_WDATA;
      end
   end

   // Housekeeping: command bits stay set until their operation ends or, for one-shot, a soft restore
   always @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         // Power-up starts with the trim copy pending
         hk_reg <= `RST_HK_CTRL | 8'h80;
      end else if (hk_reg[`HK_SOFT_RST]) begin
         hk_reg <= set_bit(`RST_HK_CTRL, `HK_RELOAD,
                           hk_reg[`HK_RELOAD] & ~reload_clr);
      end else if (hk_wr) begin
         // Reserved bit 1 kept at zero; a write neither drops nor revives a command
         hk_reg <= {ACC_WDATA[7] | (hk_reg[`HK_RELOAD] & ~reload_clr), ACC_WDATA[6:2], 1'b0,
                    (ACC_WDATA[0] & (rate_now == 3'h0)) |
                    (hk_reg[`HK_ONE_SHOT] & ~shot_clr)};
      end else begin
         if (reload_clr)
            hk_reg[`HK_RELOAD] <= 1'b0;
         if (shot_clr)
            hk_reg[`HK_ONE_SHOT] <= 1'b0;
      end
   end

   // Trim copy sequencer
   always @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         trim_cnt_reg <= 16'h0000;
         trim_busy_reg <= 1'b0;
         trim_wait_reg <= 1'b0;
         TRIM_LOAD <= 1'b0;
      end else if (hk_reg[`HK_RELOAD] && !trim_busy_reg && !trim_wait_reg) begin
         trim_busy_reg <= 1'b1;
         trim_cnt_reg <= TRIM_CYCLES[15:0];
         TRIM_LOAD <= 1'b1;
      end else if (trim_busy_reg) begin
         if (trim_cnt_reg == 16'h0000) begin
            trim_busy_reg <= 1'b0;
            trim_wait_reg <= 1'b1;
            TRIM_LOAD <= 1'b0;
         end else begin
            trim_cnt_reg <= trim_cnt_reg - 16'h0001;
         end
      end else if (reload_clr) begin
         trim_wait_reg <= 1'b0;
      end
   end

   // Acquisition sequencer: single-shot from power-down or rate-driven
   always @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= ST_IDLE;
         conv_cnt_reg <= 32'h0000_0000;
         oneshot_run_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (rate_now == 3'h0 && hk_reg[`HK_ONE_SHOT]) begin
                  state_reg <= ST_CONV;
                  oneshot_run_reg <= 1'b1;
                  conv_cnt_reg <= CONV_CYCLES - 1;
               end else if (rate_now != 3'h0 && rate_tick) begin
                  state_reg <= ST_CONV;
                  oneshot_run_reg <= 1'b0;
                  conv_cnt_reg <= CONV_CYCLES - 1;
               end
            end
            ST_CONV: begin
               if (conv_done) state_reg <= ST_DONE;
               else conv_cnt_reg <= conv_cnt_reg - 32'h0000_0001;
            end
            ST_DONE: begin
               state_reg <= ST_IDLE;
               oneshot_run_reg <= 1'b0;
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // Output byte refresh with block-update hold until high byte is read
   always @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         PRESSURE_HIGH_BYTE <= 8'h00;
         hold_reg <= 1'b0;
         new_sample_to_pin_reg <= 1'b0;
         SAMPLE_STROBE <= 1'b0;
      end else begin
         SAMPLE_STROBE <= 1'b0;
         if (conv_done && !(acq_reg[`ACQ_BDU] && hold_reg)) begin
            PRESSURE_HIGH_BYTE <= SAMPLE_IN;
            SAMPLE_STROBE <= 1'b1;
            new_sample_to_pin_reg <= 1'b1;
            hold_reg <= 1'b1;
         end else if (ACC_RD && ACC_ADDR == `ADDR_PRESS_HIGH) begin
            hold_reg <= 1'b0;
            new_sample_to_pin_reg <= 1'b0;
         end
         if (!acq_reg[`ACQ_BDU] && !conv_done) hold_reg <= 1'b0;
      end
   end

   // Read data mux; unmapped addresses read as zero
   always @* begin
      case (ACC_ADDR)
         `ADDR_IDENTITY: rd_mux = `IDENTITY_VALUE;
         `ADDR_ACQ_CTRL: rd_mux = acq_reg;
         `ADDR_HK_CTRL: rd_mux = hk_reg;
         `ADDR_IRQ_CTRL: rd_mux = irq_reg;
         `ADDR_PRESS_HIGH: rd_mux = PRESSURE_HIGH_BYTE;
         default: rd_mux = 8'h00;
      endcase
   end

   // Pin source: data flags in priority order, or pressure events
   always @* begin
      case (irq_reg[`IRQ_SRC_HI:`IRQ_SRC_LO])
         2'b00: begin
            if (irq_reg[`IRQ_NEW_SAMPLE_TO_PIN] && new_sample_to_pin_reg) irq_level = 1'b1;
            else if (irq_reg[`IRQ_WTM] && FIFO_WTM) irq_level = 1'b1;
            else if (irq_reg[`IRQ_OVR] && FIFO_OVR) irq_level = 1'b1;
            else irq_level = irq_reg[`IRQ_FULL] && FIFO_FULL;
         end
         2'b01: irq_level = PRESS_HIGH_EVT;
         2'b10: irq_level = PRESS_LOW_EVT;
         default: irq_level = PRESS_HIGH_EVT | PRESS_LOW_EVT;
      endcase
   end

   // Registered outputs and address sequencing
   always @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         ACC_RDATA <= 8'h00;
         ACC_NEXT_ADDR <= 7'h00;
         RATE_SELECT <= 3'h0;
         BANDWIDTH_DIV <= 2'b00;
         POWERED_DOWN <= 1'b1;
         SPI_THREE_WIRE <= 1'b0;
         TWO_WIRE_BUS_OFF <= 1'b0;
         FIFO_ENABLE <= 1'b0;
         HALT_AT_WATERMARK <= 1'b0;
         NEW_SAMPLE <= 1'b0;
         CFG_RESTORE <= 1'b0;
         IRQ_PIN_OUT <= 1'b0;
         IRQ_PIN_OE <= 1'b0;
      end else begin
         if (ACC_RD) ACC_RDATA <= rd_mux;
         if (ACC_RD || ACC_WR)
            ACC_NEXT_ADDR <= hk_reg[`HK_AUTO_INC] ? ACC_ADDR + 7'h01 : ACC_ADDR;
         RATE_SELECT <= rate_now;
         // 00 half rate, 01 ninth, 10 twentieth
         BANDWIDTH_DIV <= acq_reg[`ACQ_FILT_EN] ?
                          (acq_reg[`ACQ_FILT_CFG] ? 2'b10 : 2'b01) : 2'b00;
         POWERED_DOWN <= rate_now == 3'h0 && state_reg == ST_IDLE;
         SPI_THREE_WIRE <= acq_reg[`ACQ_WIRE];
         TWO_WIRE_BUS_OFF <= hk_reg[`HK_I2C_OFF];
         FIFO_ENABLE <= hk_reg[`HK_FIFO_EN];
         HALT_AT_WATERMARK <= hk_reg[`HK_HALT_WTM];
         NEW_SAMPLE <= new_sample_to_pin_reg;
         CFG_RESTORE <= hk_reg[`HK_SOFT_RST];
         // Open drain can only pull low: drive whenever the pin level is low
         if (irq_reg[`IRQ_OD]) begin
            IRQ_PIN_OUT <= 1'b0;
            IRQ_PIN_OE <= ~(irq_level ^ irq_reg[`IRQ_POL]);
         end else begin
            IRQ_PIN_OUT <= irq_level ^ irq_reg[`IRQ_POL];
            IRQ_PIN_OE <= 1'b1;
         end
      end
   end
endmodule // baro_sensor_control_regs
`default_nettype wire

// File: bench/baro_host_model.sv
// Host model: single-byte register accesses, driven on falling edges.
// Assumes the bank takes a request on the rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module baro_host_model (
   input wire logic clk,
   input wire logic [7:0] rdata,
   output logic [6:0] addr,
   output logic wr,
   output logic rd,
   output logic [7:0] wdata,
   output logic [7:0] last
);
   initial begin
      addr = 7'h00;
      wr = 1'b0;
      rd = 1'b0;
      wdata = 8'h00;
      last = 8'h00;
   end
   // Fixed-zero bits always written clear; stale data inverted after use
   task automatic wr_byte(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      addr = a;
      wdata = d & ((a == 7'h10) ? 8'h7f : (a == 7'h11) ? 8'hfd : 8'hff);
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      wdata = ~wdata;
   endtask
   // Single-byte reads only, so a held sample is never mixed
   task automatic rd_byte(input logic [6:0] a);
      @(negedge clk);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      last = rdata;
   endtask
endmodule // baro_host_model
`default_nettype wire

// File: bench/baro_regs_props.sv
// Checker for the control bank, watching top-level ports only.
// Assumes the bench has set CONV_CYCLES above two.
`timescale 1ns/10ps
`default_nettype none
`include "baro_ctrl_defs.vh"
module baro_regs_props (
   input wire logic CORE_CLK,
   input wire logic RESETN,
   input wire logic [6:0] ACC_ADDR,
   input wire logic ACC_RD,
   input wire logic ACC_WR,
   input wire logic [7:0] ACC_RDATA,
   input wire logic [6:0] ACC_NEXT_ADDR,
   input wire logic [2:0] RATE_SELECT,
   input wire logic POWERED_DOWN,
   input wire logic SAMPLE_STROBE,
   input wire logic NEW_SAMPLE,
   input wire logic TRIM_LOAD,
   input wire logic CFG_RESTORE
);
   default clocking cb @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   ident_read_a: assert property (ACC_RD && ACC_ADDR == 7'h0f |=> ACC_RDATA == `IDENTITY_VALUE)
      else $error("identity read wrong");
   addr_step_a: assert property ((ACC_RD || ACC_WR) |=> ACC_NEXT_ADDR == $past(ACC_ADDR)
      || ACC_NEXT_ADDR == $past(ACC_ADDR) + 7'd1) else $error("next address wrong");
   run_awake_a: assert property ((RATE_SELECT != 3'd0) [*2] |-> !POWERED_DOWN)
      else $error("asleep while running");
   down_quiet_a: assert property (POWERED_DOWN [*3] |-> !SAMPLE_STROBE)
      else $error("sample while powered down");
   strobe_pulse_a: assert property (SAMPLE_STROBE |=> !SAMPLE_STROBE)
      else $error("strobe too long");
   sample_flag_a: assert property (SAMPLE_STROBE |=> NEW_SAMPLE)
      else $error("no new sample flag");
   restore_pulse_a: assert property (CFG_RESTORE |=> !CFG_RESTORE)
      else $error("restore not self-clearing");
   boot_trim_a: assert property ($rose(RESETN) |=> TRIM_LOAD)
      else $error("no trim copy at power-up");
endmodule // baro_regs_props
bind baro_sensor_control_regs baro_regs_props u_props (.CORE_CLK(CORE_CLK), .RESETN(RESETN),
   .ACC_ADDR(ACC_ADDR), .ACC_RD(ACC_RD), .ACC_WR(ACC_WR), .ACC_RDATA(ACC_RDATA),
   .ACC_NEXT_ADDR(ACC_NEXT_ADDR), .RATE_SELECT(RATE_SELECT), .POWERED_DOWN(POWERED_DOWN),
   .SAMPLE_STROBE(SAMPLE_STROBE), .NEW_SAMPLE(NEW_SAMPLE), .TRIM_LOAD(TRIM_LOAD),
   .CFG_RESTORE(CFG_RESTORE));
`default_nettype wire

// File: bench/tb.sv
// Self-checking bench for the control bank against a register model.
// Assumes short conversion and trim counts set by parameter here.
`timescale 1ns/10ps
`default_nettype none
`include "baro_ctrl_defs.vh"
`define CK(g, e) begin total_checks++; if ((g) !== (e)) begin err_total++; \
   $display("unexpected %0t got %h exp %h", $time, g, e); end end
module tb;
   logic core_clk, resetn, acc_wr, acc_rd, full, wtm, ovr, p_hi, p_lo, act, ns;
   logic trim, strobe, nsamp, restore, pin, oe, pd, three_w, i2c_off, fifo_en, halt;
   logic [6:0] acc_addr, next_addr;
   logic [7:0] wdata, rdata, last, sample, press, m10, m11, m12;
   logic [2:0] rate;
   logic [1:0] bw;
   logic [31:0] r;
   integer err_total = 0, total_checks = 0, seed = 32'h51bae803, i, k;
   baro_host_model u_baro_host_model (.clk(core_clk), .rdata(rdata), .addr(acc_addr),
      .wr(acc_wr), .rd(acc_rd), .wdata(wdata), .last(last));
   baro_sensor_control_regs #(.CONV_CYCLES(4), .TRIM_CYCLES(2)) u_baro_sensor_control_regs (
      .CORE_CLK(core_clk), .RESETN(resetn), .ACC_ADDR(acc_addr), .ACC_WR(acc_wr),
      .ACC_RD(acc_rd), .ACC_WDATA(wdata), .ACC_FIRST(1'b0), .SAMPLE_IN(sample),
      .FIFO_FULL(full), .FIFO_WTM(wtm), .FIFO_OVR(ovr), .PRESS_HIGH_EVT(p_hi),
      .PRESS_LOW_EVT(p_lo), .ACC_RDATA(rdata), .ACC_NEXT_ADDR(next_addr), .RATE_SELECT(rate),
      .BANDWIDTH_DIV(bw), .POWERED_DOWN(pd), .SPI_THREE_WIRE(three_w),
      .TWO_WIRE_BUS_OFF(i2c_off), .FIFO_ENABLE(fifo_en), .HALT_AT_WATERMARK(halt),
      .TRIM_LOAD(trim), .SAMPLE_STROBE(strobe), .PRESSURE_HIGH_BYTE(press),
      .NEW_SAMPLE(nsamp), .CFG_RESTORE(restore), .IRQ_PIN_OUT(pin), .IRQ_PIN_OE(oe));
   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   task automatic print_verdict();
      if (err_total == 0 && total_checks > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Model keeps only stored bits; command bits self-clear
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      u_baro_host_model.wr_byte(a, d);
      if (a == 7'h10) m10 = d & 8'h7f;
      if (a == 7'h11) m11 = d & 8'h78;
      if (a == 7'h12) m12 = d;
      if (a == 7'h11 && d[2]) begin
         m10 = 8'h00;
         m11 = 8'h10;
         m12 = 8'h00;
      end
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      u_baro_host_model.rd_byte(a);
      `CK(last, e)
   endtask
   // Outputs lag the register by a cycle, so two are allowed
   task automatic chk_out();
      repeat (2) @(negedge core_clk);
      `CK(rate, m10[6:4])
      `CK(pd, m10[6:4] == 3'd0)
      `CK(bw, m10[3] ? (m10[2] ? 2'b10 : 2'b01) : 2'b00)
      `CK({three_w, i2c_off}, {m10[0], m11[3]})
      `CK({fifo_en, halt}, m11[6:5])
   endtask
   task automatic wait_strobe();
      for (k = 0; k < 100 && strobe !== 1'b1; k++) @(negedge core_clk);
   endtask
   initial begin
      {resetn, full, wtm, ovr, p_hi, p_lo, ns} = 7'h00;
      sample = 8'h00;
      {m10, m11, m12} = 24'h00_1000;
      repeat (2) @(negedge core_clk);
      resetn = 1'b1;
      repeat (8) @(negedge core_clk);
      rd(7'h0f, `IDENTITY_VALUE);
      rd(7'h10, 8'h00);
      rd(7'h11, 8'h10);
      rd(7'h12, 8'h00);
      for (i = 0; i < 12; i++) begin
         r = $random(seed);
         wr(7'h10, r[7:0]);
         wr(7'h11, r[15:8] & 8'h78);
         wr(7'h12, r[23:16]);
         chk_out();
         `CK(next_addr, m11[4] ? 7'h13 : 7'h12)
         rd(7'h10, m10);
         rd(7'h11, m11);
      end
      wr(7'h13, 8'hff);
      wr(7'h0f, 8'h00);
      rd(7'h13, 8'h00);
      rd(7'h0f, `IDENTITY_VALUE);
      wr(7'h10, 8'h10);
      wr(7'h11, 8'h11);
      rd(7'h11, 8'h10);
      wr(7'h10, 8'h00);
      sample = r[31:24];
      wr(7'h11, 8'h11);
      rd(7'h11, 8'h11);
      wait_strobe();
      `CK(strobe, 1'b1)
      repeat (2) @(negedge core_clk);
      `CK({press, nsamp, pd}, {sample, 2'b11})
      ns = 1'b1;
      rd(7'h11, 8'h10);
      // Open drain only pulls low, in either polarity
      for (i = 0; i < 24; i++) begin
         r = $random(seed);
         wr(7'h12, r[7:0]);
         {full, wtm, ovr, p_hi, p_lo} = r[12:8];
         repeat (3) @(negedge core_clk);
         act = m12[1:0] == 2'd1 ? p_hi : m12[1:0] == 2'd2 ? p_lo : m12[1:0] == 2'd3 ?
            (p_hi | p_lo) : (m12[2] & ns | m12[4] & wtm | m12[3] & ovr | m12[5] & full);
         if (m12[6])
            `CK({oe, pin}, {~(act ^ m12[7]), 1'b0})
         else
            `CK({oe, pin}, {1'b1, act ^ m12[7]})
      end
      // Held outputs: a second sample is dropped until the high byte is read
      wr(7'h10, 8'h02);
      sample = r[7:0];
      wr(7'h11, 8'h11);
      wait_strobe();
      sample = ~r[7:0];
      wr(7'h11, 8'h11);
      repeat (12) @(negedge core_clk);
      `CK({press, strobe}, {r[7:0], 1'b0})
      rd(7'h2a, r[7:0]);
      `CK(nsamp, 1'b0)
      wr(7'h11, 8'h11);
      wait_strobe();
      `CK(strobe, 1'b1)
      rd(7'h2a, ~r[7:0]);
      wr(7'h10, 8'h5f);
      wr(7'h11, 8'h04);
      repeat (3) @(negedge core_clk);
      rd(7'h10, 8'h00);
      rd(7'h12, 8'h00);
      chk_out();
      wr(7'h11, 8'h90);
      for (k = 0; k < 20 && trim !== 1'b1; k++) @(negedge core_clk);
      `CK(trim, 1'b1)
      for (k = 0; k < 20 && trim !== 1'b0; k++) @(negedge core_clk);
      repeat (3) @(negedge core_clk);
      rd(7'h11, 8'h10);
      print_verdict();
   end
   // Run needs about 400 cycles; cut off at 20,000
   initial begin
      #400000;
      err_total++;
      print_verdict();
   end
endmodule // tb
`default_nettype wire
